// ===== logic/cpm_top.sv
// charger fault supervision, bridge mode selection and register slave
`timescale 1ns/100ps
module cpm_top
    import cpm_pkg::*;
#(
    parameter int unsigned WOC_CLEAR_CYCLES = WOC_CLEAR_CYC,
    parameter int unsigned TEMP_QUAL_CYCLES = TEMP_QUAL_CYC,
    parameter int unsigned RETRY_LONG_CYCLES = RETRY_LONG_CYC,
    parameter int unsigned RETRY_SHORT_CYCLES = RETRY_SHORT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire cpm_sense_t sense_i,
    input wire logic int_active_i,
    output logic switching_en_o,
    output logic precharge_en_o,
    output logic adapter_present_flag_o,
    output cpm_fets_t fets_o,
    output logic reverse_active_o,
    output logic sense_adapter_node_o,
    output logic [15:0] sys_voltage_target_o,
    output logic cmp_ref_2v_sel_o,
    output logic comparator_irq_pin_o,
    output logic comparator_irq_pin_oe_o
);
    localparam int unsigned TICK_W = $clog2(WOC_TICK_CYC);
    localparam int unsigned PER_W = $clog2(WOC_CLEAR_CYCLES);
    localparam int unsigned DLY_W = $clog2(RETRY_LONG_CYCLES + RETRY_SHORT_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WOC_TICK_CYC - 1);
    localparam logic [PER_W-1:0] PER_LAST = PER_W'(WOC_CLEAR_CYCLES - 1);
    localparam logic [DLY_W-1:0] DLY_LONG = DLY_W'(RETRY_LONG_CYCLES - 1);
    localparam logic [DLY_W-1:0] DLY_SHORT = DLY_W'(RETRY_SHORT_CYCLES - 1);

    generate
        if (WOC_CLEAR_CYCLES < 2 || RETRY_LONG_CYCLES < 1 || RETRY_SHORT_CYCLES < 1
            || TEMP_QUAL_CYCLES < 1) begin : g_chk
            $error("cpm_top timing parameters out of range");
        end
    endgenerate

    typedef struct packed {
        logic [15:0] ctrl_b;
        logic [15:0] ctrl_d;
        logic [15:0] target;
        logic rev_en;
        logic [2:0] events;
        cpm_state_t st;
        cpm_mode_t mode;
        logic ov;
        logic woc_hold;
        logic [2:0] woc_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic [PER_W-1:0] per_cnt;
        logic [DLY_W-1:0] dly_cnt;
        logic [31:0] prdata;
        logic sw_en;
        logic prechg;
        logic rev_act;
        cpm_fets_t fets;
        logic ref_2v;
        logic pin_low;
    } cpm_top_st_t;

    cpm_top_st_t r;
    cpm_top_st_t r_nxt;
    cpm_sense_t s;
    logic rail_ok;
    logic temp_ok;
    logic rail_restart;
    logic temp_restart;

    cpm_sync #(
        .WIDTH($bits(cpm_sense_t))
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(sense_i),
        .sync_o(s)
    );

    assign rail_restart = r.st != ST_PRECHG;
    assign temp_restart = r.st != ST_THERM;

    // rail must stay above the short level for the whole debounce window
    cpm_qualify #(
        .CYCLES(RAIL_DEB_CYC)
    ) u_rail_qual (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .restart_i(rail_restart),
        .level_i(s.rail_above_min),
        .qualified_o(rail_ok)
    );

    cpm_qualify #(
        .CYCLES(TEMP_QUAL_CYCLES)
    ) u_temp_qual (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .restart_i(temp_restart),
        .level_i(s.temp_below_recover),
        .qualified_o(temp_ok)
    );

    always_comb begin
        logic wr;
        logic rd;
        logic mapped;
        logic [2:0] ev_set;
        logic [2:0] ev_clr;
        logic woc_dis;
        logic woc_trip;
        logic tick_end;
        logic per_end;
        logic woc_hit;
        logic batt_only;
        logic cmp_en;
        logic above;
        logic out_high;
        logic [DLY_W-1:0] dly_load;
        cpm_mode_t md;
        wr = 1'b0;
        rd = 1'b0;
        mapped = 1'b0;
        ev_set = '0;
        ev_clr = '0;
        woc_dis = 1'b0;
        woc_trip = 1'b0;
        tick_end = 1'b0;
        per_end = 1'b0;
        woc_hit = 1'b0;
        batt_only = 1'b0;
        cmp_en = 1'b0;
        above = 1'b0;
        out_high = 1'b0;
        dly_load = '0;
        md = r.mode;
        r_nxt = r;

        // register bus
        mapped = paddr_i inside {ADDR_CTRL_B, ADDR_CTRL_D, ADDR_TARGET,
                                 ADDR_STATUS, ADDR_EVENTS, ADDR_REVERSE};
        wr = psel_i && penable_i && pwrite_i && mapped;
        rd = psel_i && !penable_i && !pwrite_i;
        if (wr) begin
            unique case (paddr_i)
                ADDR_CTRL_B: r_nxt.ctrl_b = pwdata_i[15:0];
                ADDR_CTRL_D: r_nxt.ctrl_d = pwdata_i[15:0];
                ADDR_TARGET: r_nxt.target = pwdata_i[15:0];
                ADDR_EVENTS: ev_clr = pwdata_i[2:0];
                ADDR_REVERSE: r_nxt.rev_en = pwdata_i[0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (paddr_i)
                ADDR_CTRL_B: r_nxt.prdata = {16'h0000, r.ctrl_b};
                ADDR_CTRL_D: r_nxt.prdata = {16'h0000, r.ctrl_d};
                ADDR_TARGET: r_nxt.prdata = {16'h0000, r.target};
                ADDR_STATUS: r_nxt.prdata = {15'h0000, r.pin_low, adapter_present_flag_o,
                                             r.prechg, r.sw_en, r.rev_act, r.mode,
                                             r.woc_cnt, r.ov, r.st};
                ADDR_EVENTS: r_nxt.prdata = {29'h00000000, r.events};
                ADDR_REVERSE: r_nxt.prdata = {31'h00000000, r.rev_en};
                default: r_nxt.prdata = 32'h00000000;
            endcase
        end

        // system overvoltage, no debounce on recovery
        if (s.rail_over_ov) begin
            r_nxt.ov = 1'b1;
            ev_set[EV_OV] = 1'b1;
        end else if (r.ov && s.rail_below_recover) begin
            r_nxt.ov = 1'b0;
        end

        // way-overcurrent counter
        woc_dis = r.ctrl_d[CD_WOC_DIS];
        woc_trip = (s.adp_cur_trip || s.bat_cur_trip) && !woc_dis;
        tick_end = r.tick_cnt == TICK_LAST;
        per_end = r.per_cnt == PER_LAST;
        r_nxt.tick_cnt = tick_end ? '0 : r.tick_cnt + TICK_W'(1);
        r_nxt.per_cnt = per_end ? '0 : r.per_cnt + PER_W'(1);
        woc_hit = woc_trip && tick_end && r.woc_cnt == WOC_LIMIT - 3'h1;
        if (per_end || woc_dis || woc_hit) begin
            r_nxt.woc_cnt = 3'h0;
        end else if (woc_trip && tick_end) begin
            r_nxt.woc_cnt = r.woc_cnt + 3'h1;
        end

        // retry delay length
        dly_load = r.ctrl_b[CB_RETRY_SEL] ? DLY_SHORT : DLY_LONG;

        // supervision sequence
        unique case (r.st)
            ST_IDLE: begin
                if (r.target != 16'h0000) begin
                    r_nxt.st = ST_PRECHG;
                end
            end
            ST_PRECHG: begin
                if (r.target == 16'h0000) begin
                    r_nxt.st = ST_IDLE;
                end else if (rail_ok) begin
                    r_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (r.target == 16'h0000) begin
                    r_nxt.st = ST_IDLE;
                end
            end
            ST_THERM: begin
                if (temp_ok) begin
                    r_nxt.st = ST_RETRY;
                    r_nxt.dly_cnt = dly_load;
                end
            end
            ST_RETRY: begin
                if (r.dly_cnt == '0) begin
                    r_nxt.st = ST_PRECHG;
                    r_nxt.woc_hold = 1'b0;
                end else begin
                    r_nxt.dly_cnt = r.dly_cnt - DLY_W'(1);
                end
            end
            default: r_nxt.st = ST_IDLE;
        endcase
        // overcurrent shutdown outranks the sequence, heat outranks both
        if (woc_hit && r.st != ST_THERM) begin
            r_nxt.st = ST_RETRY;
            r_nxt.woc_hold = 1'b1;
            r_nxt.dly_cnt = dly_load;
            ev_set[EV_WOC] = 1'b1;
        end
        if (s.temp_over_shut) begin
            r_nxt.st = ST_THERM;
            ev_set[EV_THERM] = 1'b1;
        end
        // a fresh event beats a simultaneous software clear
        r_nxt.events = (r.events & ~ev_clr) | ev_set;

        // forward ratio hysteresis
        unique case (r.mode)
            MD_BOOST: if (s.adp_above_94) md = MD_BUCKBOOST;
            MD_BUCKBOOST: begin
                if (s.adp_above_112) begin
                    md = MD_BUCK;
                end else if (s.adp_below_92) begin
                    md = MD_BOOST;
                end
            end
            MD_BUCK: if (s.adp_below_106) md = MD_BUCKBOOST;
            default: md = MD_BUCKBOOST;
        endcase
        r_nxt.mode = md;

        r_nxt.rev_act = r.rev_en && s.reverse_enable_pin && s.vbat_above_min;
        r_nxt.sw_en = (r_nxt.st == ST_RUN) && !r_nxt.ov;
        r_nxt.prechg = r_nxt.st == ST_PRECHG;

        // bridge roles, all off while not switching
        r_nxt.fets = '{FET_OFF, FET_OFF, FET_OFF, FET_OFF};
        if (r_nxt.sw_en) begin
            if (!r_nxt.rev_act) begin
                unique case (md)
                    MD_BUCK: r_nxt.fets = '{FET_CTRL, FET_SYNC, FET_OFF, FET_ON};
                    MD_BOOST: r_nxt.fets = '{FET_ON, FET_OFF, FET_CTRL, FET_SYNC};
                    default: r_nxt.fets = '{FET_CTRL, FET_SYNC, FET_CTRL, FET_SYNC};
                endcase
            end else begin
                unique case (md)
                    MD_BUCK: r_nxt.fets = '{FET_ON, FET_OFF, FET_SYNC, FET_CTRL};
                    MD_BOOST: r_nxt.fets = '{FET_SYNC, FET_CTRL, FET_OFF, FET_ON};
                    default: r_nxt.fets = '{FET_SYNC, FET_CTRL, FET_SYNC, FET_CTRL};
                endcase
            end
        end

        // general comparator and shared open-drain pin
        batt_only = !s.adapter_valid;
        cmp_en = r.ctrl_b[CB_CMP_EN] && !(batt_only && r.ctrl_d[CD_CMP_BATT_DIS]);
        r_nxt.ref_2v = r.ctrl_b[CB_REF_SEL] && !batt_only;
        above = r.ref_2v ? s.cmp_above_hi : s.cmp_above_lo;
        out_high = above ^ r.ctrl_b[CB_POLARITY];
        r_nxt.pin_low = (cmp_en && !out_high) || int_active_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.ctrl_b <= CTRL_B_RST;
            r.ctrl_d <= CTRL_D_RST;
            r.target <= TARGET_RST;
            r.st <= ST_IDLE;
            r.mode <= MD_BUCKBOOST;
        end else begin
            r <= r_nxt;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !(paddr_i inside {ADDR_CTRL_B, ADDR_CTRL_D,
        ADDR_TARGET, ADDR_STATUS, ADDR_EVENTS, ADDR_REVERSE});
    assign switching_en_o = r.sw_en;
    assign precharge_en_o = r.prechg;
    assign adapter_present_flag_o = s.adapter_valid && !r.woc_hold;
    assign fets_o = r.fets;
    assign reverse_active_o = r.rev_act;
    assign sense_adapter_node_o = r.rev_act;
    assign sys_voltage_target_o = r.target;
    assign cmp_ref_2v_sel_o = r.ref_2v;
    assign comparator_irq_pin_o = 1'b0;
    assign comparator_irq_pin_oe_o = r.pin_low;
endmodule

// ===== pkg/cpm_pkg.sv
// constants and types for the charger protection and mode control block
// How it works
// - rail below 0.6V: no switching, 10mA precharge source on; rail only checked in precharge, a drop while switching is ignored.
// - rail above 0.6V for the debounce time: precharge off, switching allowed.
// - every idle (target 0V) to switching change reruns precharge qualification.
// - rail 800mV above target flags overvoltage and halts switching.
// - overvoltage clears without debounce once rail is 400mV below trip.
// - way-overcurrent trips at 12A adapter or 20A battery discharge.
// - while tripped, event counter steps once per 10us tick.
// - counter at 7 stops switching at once and drops adapter-present flag.
// - event counter cleared every 50ms regardless of comparator.
// - after shutdown wait 1.3s or 150ms by ctrl B bit 11, restart.
// - ctrl D bit 9 disables way-overcurrent protection entirely.
// - junction above 140C stops switching.
// - restart after temp below recovery for qualify time, then retry delay.
// - comparator reference 1.2V or 2V by ctrl B bit 4.
// - ctrl B bit 2 clear: output high when above reference; set inverts.
// - battery-only: enabled by default, ctrl D bit 12 gates, 1.2V, needs B bit 3.
// - shared pin pulled low by comparator or interrupt, each alone when other off.
// - forward buck, boost and buck-boost FET roles per table.
// - reverse modes swap FET roles; output sensed at adapter node.
// - rising adapter: boost to buck-boost above 94%, to buck above 112%.
// - falling adapter: buck to buck-boost below 106%, to boost below 92%.
// - reverse only with register enable, pin enable and battery above 5.2V.
package cpm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RAIL_DEB_NS = 10_000;
    localparam int unsigned RAIL_DEB_CYC = (RAIL_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WOC_TICK_NS = 10_000;
    localparam int unsigned WOC_TICK_CYC = WOC_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned WOC_CLEAR_NS = 50_000_000;
    localparam int unsigned WOC_CLEAR_CYC = WOC_CLEAR_NS / CLK_PERIOD_NS;
    localparam int unsigned TEMP_QUAL_NS = 100_000;
    localparam int unsigned TEMP_QUAL_CYC = (TEMP_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_LONG_NS = 1_300_000_000;
    localparam int unsigned RETRY_LONG_CYC = RETRY_LONG_NS / CLK_PERIOD_NS;
    localparam int unsigned RETRY_SHORT_NS = 150_000_000;
    localparam int unsigned RETRY_SHORT_CYC = RETRY_SHORT_NS / CLK_PERIOD_NS;
    localparam logic [2:0] WOC_LIMIT = 3'h7;

    localparam logic [7:0] ADDR_CTRL_B = 8'h00;
    localparam logic [7:0] ADDR_CTRL_D = 8'h04;
    localparam logic [7:0] ADDR_TARGET = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_EVENTS = 8'h10;
    localparam logic [7:0] ADDR_REVERSE = 8'h14;
    localparam logic [15:0] CTRL_B_RST = 16'h0000;
    localparam logic [15:0] CTRL_D_RST = 16'h0000;
    localparam logic [15:0] TARGET_RST = 16'h0000;

    localparam int unsigned CB_POLARITY = 2;
    localparam int unsigned CB_CMP_EN = 3;
    localparam int unsigned CB_REF_SEL = 4;
    localparam int unsigned CB_RETRY_SEL = 11;
    localparam int unsigned CD_WOC_DIS = 9;
    localparam int unsigned CD_CMP_BATT_DIS = 12;
    localparam int unsigned EV_WOC = 0;
    localparam int unsigned EV_THERM = 1;
    localparam int unsigned EV_OV = 2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PRECHG = 5'b00010,
        ST_RUN = 5'b00100,
        ST_THERM = 5'b01000,
        ST_RETRY = 5'b10000
    } cpm_state_t;

    typedef enum logic [2:0] {
        MD_BUCK = 3'b001,
        MD_BUCKBOOST = 3'b010,
        MD_BOOST = 3'b100
    } cpm_mode_t;

    typedef enum logic [1:0] {
        FET_OFF = 2'h0,
        FET_ON = 2'h1,
        FET_CTRL = 2'h2,
        FET_SYNC = 2'h3
    } cpm_fet_role_t;

    typedef struct packed {
        cpm_fet_role_t input_high_fet;
        cpm_fet_role_t input_low_fet;
        cpm_fet_role_t output_low_fet;
        cpm_fet_role_t output_high_fet;
    } cpm_fets_t;

    // analog comparator levels, all asynchronous to sys_clk_i
    typedef struct packed {
        logic rail_above_min;
        logic rail_over_ov;
        logic rail_below_recover;
        logic adp_cur_trip;
        logic bat_cur_trip;
        logic temp_over_shut;
        logic temp_below_recover;
        logic cmp_above_lo;
        logic cmp_above_hi;
        logic adapter_valid;
        logic vbat_above_min;
        logic adp_above_94;
        logic adp_above_112;
        logic adp_below_106;
        logic adp_below_92;
        logic reverse_enable_pin;
    } cpm_sense_t;
endpackage

// ===== logic/cpm_sync.sv
// two-stage synchroniser for asynchronous levels
`timescale 1ns/100ps
module cpm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cpm_sync_st_t;

    cpm_sync_st_t r;
    cpm_sync_st_t r_nxt;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("cpm_sync WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        r_nxt = r;
        r_nxt.meta = async_i;
        r_nxt.stable = r.meta;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign sync_o = r.stable;
endmodule

// ===== logic/cpm_qualify.sv
// qualifies a level that must hold continuously for a number of cycles
`timescale 1ns/100ps
module cpm_qualify #(
    parameter int unsigned CYCLES = 1250
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic level_i,
    output logic qualified_o
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
    } cpm_qual_st_t;

    cpm_qual_st_t r;
    cpm_qual_st_t r_nxt;

    generate
        if (CYCLES < 1) begin : g_chk
            $error("cpm_qualify CYCLES must be at least 1");
        end
    endgenerate

    always_comb begin
        r_nxt = r;
        if (restart_i || !level_i) begin
            r_nxt.cnt = '0;
            r_nxt.done = 1'b0;
        end else if (r.cnt != LAST) begin
            r_nxt.cnt = r.cnt + CW'(1);
            r_nxt.done = (r.cnt + CW'(1)) == LAST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign qualified_o = r.done;
endmodule

// ===== tb/cpm_top_assertions.sv
// concurrent checks on the charger protection block ports
`timescale 1ns/100ps
module cpm_top_assertions
    import cpm_pkg::*;
(
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [7:0] paddr_i,
    input logic [31:0] pwdata_i,
    input cpm_sense_t sense_i,
    input logic int_active_i,
    input logic switching_en_o,
    input logic precharge_en_o,
    input logic adapter_present_flag_o,
    input logic reverse_active_o,
    input logic sense_adapter_node_o,
    input logic cmp_ref_2v_sel_o,
    input logic comparator_irq_pin_oe_o
);
    logic ref_r;
    // ref select as written on the bus
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_r <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL_B) begin
            ref_r <= pwdata_i[CB_REF_SEL];
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // four cycles covers the two-stage sync plus the state register
    sequence s_ov_trip;
        sense_i.rail_over_ov [*4];
    endsequence
    sequence s_hot;
        sense_i.temp_over_shut [*4];
    endsequence
    a_prechg_blocks: assert property (precharge_en_o |-> !switching_en_o)
        else $error("switch in precharge");
    a_rail_qualified: assert property ($rose(switching_en_o) |-> $past(sense_i.rail_above_min, 3))
        else $error("rail unqualified");
    a_ov_halts: assert property (s_ov_trip |=> !switching_en_o)
        else $error("ov switching");
    a_hot_halts: assert property (s_hot |=> !switching_en_o)
        else $error("hot switching");
    a_woc_stops: assert property ($fell(adapter_present_flag_o) && sense_i.adapter_valid |-> !switching_en_o)
        else $error("woc switching");
    a_ref_select: assert property ((ref_r && sense_i.adapter_valid) [*4] |=> cmp_ref_2v_sel_o)
        else $error("ref not 2v");
    a_batt_ref: assert property ((!sense_i.adapter_valid) [*4] |=> !cmp_ref_2v_sel_o)
        else $error("batt ref high");
    a_irq_pulls: assert property (int_active_i |=> comparator_irq_pin_oe_o)
        else $error("irq not pulled");
    a_reverse_gate: assert property ($rose(reverse_active_o) |->
        $past(sense_i.vbat_above_min, 3) && $past(sense_i.reverse_enable_pin, 3))
        else $error("reverse ungated");
    a_sense_node: assert property (sense_adapter_node_o == reverse_active_o)
        else $error("node mismatch");
endmodule

// ===== tb/cpm_rail_model.sv
// system rail model: charges only while the precharge source is on
`timescale 1ns/100ps
module cpm_rail_model (
    input wire logic sys_clk_i,
    input wire logic precharge_i,
    input wire logic short_i,
    output logic rail_above_min_o
);
    logic [5:0] chg_r = 6'h00;
    // charged rail stays up until shorted
    always @(posedge sys_clk_i) begin
        if (short_i) begin
            chg_r <= 6'h00;
        end else if (precharge_i && chg_r != 6'h3F) begin
            chg_r <= chg_r + 6'h01;
        end
    end
    assign rail_above_min_o = (chg_r == 6'h3F);
endmodule

// ===== tb/cpm_top_tb.sv
// testbench for the charger protection block
`timescale 1ns/100ps
module cpm_top_tb
    import cpm_pkg::*;
();
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, int_act = 1'b0, rail_short = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rail_ok, sw, pre, flag, rev, node, ref2v, pin, pin_oe;
    logic [15:0] tgt;
    cpm_fets_t fets;
    cpm_sense_t sense = '0, sense_in;
    logic [3:0] mcode [5] = '{4'hC, 4'h8, 4'hA, 4'h3, 4'hA};
    cpm_fets_t mfets [5] = '{8'hB1, 8'hB1, 8'hBB, 8'h4B, 8'hBB};
    int bad_count = 0, checks = 0, cyc = 0;
    wire [31:0] st = {30'h0, pre, sw};
    cpm_top #(.WOC_CLEAR_CYCLES(20000), .TEMP_QUAL_CYCLES(20), .RETRY_LONG_CYCLES(100),
        .RETRY_SHORT_CYCLES(40)) cpm_top_i (.sys_clk_i, .rst_n_i,
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .sense_i(sense_in), .int_active_i(int_act), .switching_en_o(sw), .precharge_en_o(pre),
        .adapter_present_flag_o(flag), .fets_o(fets), .reverse_active_o(rev),
        .sense_adapter_node_o(node), .sys_voltage_target_o(tgt), .cmp_ref_2v_sel_o(ref2v),
        .comparator_irq_pin_o(pin), .comparator_irq_pin_oe_o(pin_oe));
    cpm_rail_model cpm_rail_model_i (.sys_clk_i, .precharge_i(pre),
        .short_i(rail_short), .rail_above_min_o(rail_ok));
    always_comb begin
        sense_in = sense;
        sense_in.rail_above_min = rail_ok;
    end
    initial forever #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_st(input string what, input logic [31:0] exp, input int lim);
        int n = 0;
        while (st !== exp && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(what, exp, st);
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    initial begin
        sense.adapter_valid <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, ADDR_CTRL_B, 32'h0);
        chk("ctrl_b rst", {16'h0, CTRL_B_RST}, rd);
        apb(1'b0, ADDR_TARGET, 32'h0);
        chk("target rst", {16'h0, TARGET_RST}, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("unmapped rd", 32'h0, rd);
        $display("test registers done");
        apb(1'b1, ADDR_TARGET, 32'h0000_1234);
        nw(3);
        chk("prechg", 32'h2, st);
        chk("target out", 32'h1234, {16'h0, tgt});
        nw(1000);
        chk("debounce", 32'h2, st);
        wait_st("sw on", 32'h1, 500);
        foreach (mcode[i]) begin
            @(posedge sys_clk_i);
            sense[4:1] <= mcode[i];
            nw(6);
            chk("fets", {24'h0, mfets[i]}, {24'h0, fets});
        end
        $display("test modes done");
        @(posedge sys_clk_i);
        sense.rail_over_ov <= 1'b1;
        nw(6);
        chk("ov stop", 32'h0, st);
        @(posedge sys_clk_i);
        sense.rail_over_ov <= 1'b0;
        sense.rail_below_recover <= 1'b1;
        nw(5);
        chk("ov resume", 32'h1, st);
        apb(1'b0, ADDR_EVENTS, 32'h0);
        chk("ov event", 32'h1, {31'h0, rd[EV_OV]});
        $display("test ov done");
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0800);
        @(posedge sys_clk_i);
        sense.adp_cur_trip <= 1'b1;
        wait_st("woc stop", 32'h0, 30000);
        chk("woc flag", 32'h0, {31'h0, flag});
        @(posedge sys_clk_i);
        sense.adp_cur_trip <= 1'b0;
        nw(25);
        chk("retry hold", 32'h0, st);
        wait_st("retry end", 32'h2, 30);
        wait_st("woc rerun", 32'h1, 1500);
        apb(1'b1, ADDR_CTRL_D, 32'h0000_0200);
        @(posedge sys_clk_i);
        sense.bat_cur_trip <= 1'b1;
        // spans 7+ ticks on one side of a clear
        nw(19000);
        chk("woc off", 32'h1, st);
        @(posedge sys_clk_i);
        sense.bat_cur_trip <= 1'b0;
        $display("test woc done");
        sense.temp_over_shut <= 1'b1;
        nw(6);
        chk("hot stop", 32'h0, st);
        @(posedge sys_clk_i);
        sense.temp_over_shut <= 1'b0;
        sense.temp_below_recover <= 1'b1;
        nw(40);
        chk("cool wait", 32'h0, st);
        wait_st("cool retry", 32'h2, 40);
        wait_st("hot rerun", 32'h1, 1500);
        $display("test thermal done");
        apb(1'b1, ADDR_TARGET, 32'h0);
        @(posedge sys_clk_i);
        rail_short <= 1'b1;
        @(posedge sys_clk_i);
        rail_short <= 1'b0;
        nw(1);
        chk("idle", 32'h0, st);
        apb(1'b1, ADDR_TARGET, 32'h0000_0F00);
        nw(3);
        chk("requal", 32'h2, st);
        wait_st("requal end", 32'h1, 1500);
        $display("test restart done");
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0018);
        nw(6);
        chk("ref 2v", 32'h1, {31'h0, ref2v});
        @(posedge sys_clk_i);
        sense.adapter_valid <= 1'b0;
        int_act <= 1'b1;
        nw(6);
        chk("ref bat", 32'h0, {31'h0, ref2v});
        chk("irq pin", 32'h1, {30'h0, pin, pin_oe});
        @(posedge sys_clk_i);
        int_act <= 1'b0;
        sense.cmp_above_lo <= 1'b1;
        nw(6);
        chk("cmp high", 32'h0, {31'h0, pin_oe});
        apb(1'b1, ADDR_CTRL_B, 32'h0000_001C);
        nw(2);
        chk("cmp inverted", 32'h1, {31'h0, pin_oe});
        apb(1'b1, ADDR_REVERSE, 32'h1);
        @(posedge sys_clk_i);
        sense.vbat_above_min <= 1'b1;
        sense.reverse_enable_pin <= 1'b1;
        nw(6);
        chk("rev on", 32'h3, {30'h0, rev, node});
        chk("rev fets", 32'hEE, {24'h0, fets});
        @(posedge sys_clk_i);
        sense.vbat_above_min <= 1'b0;
        nw(6);
        chk("rev off", 32'h0, {30'h0, rev, node});
        $display("test cmp done");
        report_and_stop();
    end
endmodule
bind cpm_top cpm_top_assertions cpm_top_assertions_i (.sys_clk_i, .rst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .sense_i, .int_active_i, .switching_en_o,
    .precharge_en_o, .adapter_present_flag_o, .reverse_active_o, .sense_adapter_node_o,
    .cmp_ref_2v_sel_o, .comparator_irq_pin_oe_o);
